// file: sbc_selftest_cfg.sv
// self-test configuration and control for the serial ATA adapter ports.
// assumes configuration cycles, link events and transmit path share I_MCLK;
// only the out-of-band detect arrives from the analog front end, unsynchronised.
`timescale 1ns/1ns
`default_nettype none
module sbc_selftest_cfg (
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    input wire logic I_PM_D3_TO_D0,
    input wire logic I_CFG_WR,
    input wire logic I_CFG_RD,
    input wire logic [7:0] I_CFG_ADDR,
    input wire logic [3:0] I_CFG_BE,
    input wire logic [31:0] I_CFG_WDATA,
    output logic [31:0] O_CFG_RDATA,
    output logic O_CFG_RVALID,
    input wire logic I_BIST_ACTIVATE,
    input wire logic I_SW_COMRESET,
    input wire logic I_OOB_SIGNAL,
    output logic O_OOB_SIGNAL,
    output logic O_DISCONNECTED,
    input wire logic I_PATTERN_OK,
    output logic O_SELFTEST_DONE,
    output logic O_TX_VALID,
    input wire logic I_TX_READY,
    output sbc_pkg::sbc_tx_word_t O_TX_WORD
);
    import sbc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sbc_state_t st_reg;
    sbc_state_t st_next;
    logic [31:0] wmask;
    logic [32:0] target;
    logic [32:0] verified_inc;
    logic selftest_active;
    logic tmode_active;
    logic gen_ready;
    sbc_tx_word_t gen_word;
    logic gen_push;

    // byte-enable expansion for configuration writes
    assign wmask = {{8{I_CFG_BE[3]}}, {8{I_CFG_BE[2]}}, {8{I_CFG_BE[1]}}, {8{I_CFG_BE[0]}}};

    // ------------------------------------------------------------
    // pattern compare target
    // ------------------------------------------------------------
    // one count serves every port and both self-test kinds
    assign selftest_active = st_reg.ctl[SBC_CTL_LINK_EN] | st_reg.ctl[SBC_CTL_SATA_EN];
    // zero is read as the largest count, needing the 33rd bit
    assign target = (st_reg.count == 32'h0000_0000) ? SBC_COUNT_MAX : {1'b0, st_reg.count};
    assign verified_inc = st_reg.verified + 33'h0_0000_0001;

    // ------------------------------------------------------------
    // transmit-only pattern source
    // ------------------------------------------------------------
    // only when link self-test runs with the transmit-only pattern
    assign tmode_active = st_reg.ctl[SBC_CTL_LINK_EN]
        & (st_reg.ctl[SBC_CTL_PAT_LO +: 4] == SBC_PAT_TMODE);
    assign gen_push = tmode_active & gen_ready;

    // alternate the two programmed dwords with the definition flags
    always_comb begin
        gen_word.data = st_reg.tx_sel ? st_reg.dword_two : st_reg.dword_one;
        gen_word.align_bypass = st_reg.definition[SBC_DEF_ALIGN_BYP];
        gen_word.scramble_bypass = st_reg.definition[SBC_DEF_SCRAM_BYP];
        gen_word.is_primitive = st_reg.definition[SBC_DEF_PRIM];
    end

    // buffer absorbs a transmit stall without losing a generated word
    sbc_pair_buf u_buf (
        .i_clk(I_MCLK),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .i_clear(~tmode_active),
        .i_in_valid(tmode_active),
        .o_in_ready(gen_ready),
        .i_in_data(gen_word),
        .o_out_valid(O_TX_VALID),
        .i_out_ready(I_TX_READY),
        .o_out_data(O_TX_WORD)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;

        // configuration writes, byte lanes honoured
        if (I_CFG_WR) begin
            unique case (I_CFG_ADDR)
                SBC_OFS_CONTROL: begin
                    // done bit is read-only; 15:12 are plain storage
                    st_next.ctl = (st_reg.ctl & ~(wmask[15:0] & SBC_CTL_WR_MASK))
                        | (I_CFG_WDATA[15:0] & wmask[15:0] & SBC_CTL_WR_MASK);
                end
                SBC_OFS_COUNT: begin
                    st_next.count = (st_reg.count & ~wmask) | (I_CFG_WDATA & wmask);
                end
                SBC_OFS_DWORD_ONE: begin
                    st_next.dword_one = (st_reg.dword_one & ~wmask) | (I_CFG_WDATA & wmask);
                end
                SBC_OFS_DWORD_TWO: begin
                    st_next.dword_two = (st_reg.dword_two & ~wmask) | (I_CFG_WDATA & wmask);
                end
                SBC_OFS_DEFINITION: begin
                    // reserved upper bits kept as storage
                    st_next.definition = (st_reg.definition & ~wmask)
                        | (I_CFG_WDATA & wmask);
                end
                default: begin
                    // unmapped offsets ignore writes
                end
            endcase
        end

        // configuration reads, answered the next cycle
        st_next.rvalid = I_CFG_RD;
        if (I_CFG_RD) begin
            unique case (I_CFG_ADDR)
                SBC_OFS_CONTROL: begin
                    st_next.rdata = {16'h0000, st_reg.ctl};
                    st_next.rdata[SBC_CTL_DONE] = st_reg.done;
                end
                SBC_OFS_COUNT: st_next.rdata = st_reg.count;
                SBC_OFS_DWORD_ONE: st_next.rdata = st_reg.dword_one;
                SBC_OFS_DWORD_TWO: st_next.rdata = st_reg.dword_two;
                SBC_OFS_DEFINITION: st_next.rdata = st_reg.definition;
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end

        // pattern compare counting; error_count_reset holds both cleared,
        // so a pattern arriving during the reset is dropped on purpose
        if (st_reg.ctl[SBC_CTL_ERR_RST]) begin
            st_next.verified = 33'h0_0000_0000;
            st_next.done = 1'b0;
        end else if (selftest_active && !st_reg.done && I_PATTERN_OK) begin
            st_next.verified = verified_inc;
            if (verified_inc == target) begin
                st_next.done = 1'b1;
            end
        end

        // disconnect mode; leaving it needs COMRESET, reset does the rest
        unique case (st_reg.disc)
            SBC_LINKED: begin
                if (I_BIST_ACTIVATE && st_reg.ctl[SBC_CTL_DISC_EN]) begin
                    st_next.disc = SBC_DISCONNECTED;
                end
            end
            SBC_DISCONNECTED: begin
                // COMRESET leaves the enable bit as programmed
                if (I_SW_COMRESET) begin
                    st_next.disc = SBC_LINKED;
                end
            end
        endcase

        // out-of-band detect: three stages, change taken when 2 and 3 agree
        st_next.oob_sync = {st_reg.oob_sync[1:0], I_OOB_SIGNAL};
        if (st_reg.oob_sync[2] == st_reg.oob_sync[1]) begin
            st_next.oob_level = st_reg.oob_sync[2];
        end
        // OOB from the device is hidden while disconnected
        st_next.oob_out = st_next.oob_level & (st_next.disc == SBC_LINKED);
        st_next.disc_out = (st_next.disc == SBC_DISCONNECTED);
        st_next.done_out = st_next.done;

        // generator alternates dwords on every accepted word
        if (!tmode_active) begin
            st_next.tx_sel = 1'b0;
        end else if (gen_push) begin
            st_next.tx_sel = ~st_reg.tx_sel;
        end

        // power-state return restores defaults except the upper control bits and the disconnect state
        if (I_PM_D3_TO_D0) begin
            st_next.ctl = (st_reg.ctl & SBC_CTL_UPPER_MASK)
                | (SBC_CTL_RESET & ~SBC_CTL_UPPER_MASK);
            st_next.count = SBC_COUNT_RESET;
            st_next.dword_one = SBC_DWORD_RESET;
            st_next.dword_two = SBC_DWORD_RESET;
            st_next.definition = SBC_DEF_RESET;
            st_next.verified = 33'h0_0000_0000;
            st_next.done = 1'b0;
            st_next.done_out = 1'b0;
            st_next.tx_sel = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // PCI reset loads every reset value (count 0000_2000, the rest zero); clock enable low freezes all
    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_reg.ctl <= SBC_CTL_RESET;
            st_reg.count <= SBC_COUNT_RESET;
            st_reg.dword_one <= SBC_DWORD_RESET;
            st_reg.dword_two <= SBC_DWORD_RESET;
            st_reg.definition <= SBC_DEF_RESET;
            st_reg.verified <= 33'h0_0000_0000;
            st_reg.done <= 1'b0;
            st_reg.disc <= SBC_LINKED;
            st_reg.oob_sync <= 3'h0;
            st_reg.oob_level <= 1'b0;
            st_reg.oob_out <= 1'b0;
            st_reg.disc_out <= 1'b0;
            st_reg.done_out <= 1'b0;
            st_reg.rdata <= 32'h0000_0000;
            st_reg.rvalid <= 1'b0;
            st_reg.tx_sel <= 1'b0;
        end else if (I_CE) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, each a flop
    // ------------------------------------------------------------
    assign O_CFG_RDATA = st_reg.rdata;
    assign O_CFG_RVALID = st_reg.rvalid;
    assign O_OOB_SIGNAL = st_reg.oob_out;
    assign O_DISCONNECTED = st_reg.disc_out;
    assign O_SELFTEST_DONE = st_reg.done_out;

endmodule : sbc_selftest_cfg
`default_nettype wire

// file: sbc_pkg.sv
// package of the self-test configuration block: offsets, fields, resets, types.
// assumes one 20 MHz clock domain shared by the configuration port and link logic.
package sbc_pkg;

    // ------------------------------------------------------------
    // register offsets in configuration space
    // ------------------------------------------------------------
    localparam logic [7:0] SBC_OFS_CONTROL = 8'hD8;
    localparam logic [7:0] SBC_OFS_COUNT = 8'hDC;
    localparam logic [7:0] SBC_OFS_DWORD_ONE = 8'hE4;
    localparam logic [7:0] SBC_OFS_DWORD_TWO = 8'hE8;
    localparam logic [7:0] SBC_OFS_DEFINITION = 8'hEC;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int SBC_CTL_LINK_EN = 0;
    localparam int SBC_CTL_PAT_LO = 2;
    localparam int SBC_CTL_ERR_RST = 6;
    localparam int SBC_CTL_DONE = 9;
    localparam int SBC_CTL_SATA_EN = 10;
    localparam int SBC_CTL_DISC_EN = 11;
    localparam logic [15:0] SBC_CTL_UPPER_MASK = 16'hF000;
    localparam logic [15:0] SBC_CTL_WR_MASK = 16'hFDFF;
    localparam logic [3:0] SBC_PAT_TMODE = 4'h7;

    // ------------------------------------------------------------
    // definition register fields and reset values
    // ------------------------------------------------------------
    localparam int SBC_DEF_ALIGN_BYP = 0;
    localparam int SBC_DEF_SCRAM_BYP = 1;
    localparam int SBC_DEF_PRIM = 2;
    localparam logic [15:0] SBC_CTL_RESET = 16'h0000;
    localparam logic [31:0] SBC_COUNT_RESET = 32'h0000_2000;
    localparam logic [31:0] SBC_DWORD_RESET = 32'h0000_0000;
    localparam logic [31:0] SBC_DEF_RESET = 32'h0000_0000;
    localparam logic [32:0] SBC_COUNT_MAX = 33'h1_0000_0000;

    // word handed to the transmit path
    typedef struct packed {
        logic [31:0] data;
        logic is_primitive;
        logic align_bypass;
        logic scramble_bypass;
    } sbc_tx_word_t;

    // two-entry buffer state
    typedef struct packed {
        sbc_tx_word_t e0;
        sbc_tx_word_t e1;
        logic v0;
        logic v1;
    } sbc_buf_state_t;

    // disconnect mode states
    typedef enum logic [0:0] {
        SBC_LINKED,
        SBC_DISCONNECTED
    } sbc_disc_t;

    // main block state
    typedef struct packed {
        logic [15:0] ctl;
        logic [31:0] count;
        logic [31:0] dword_one;
        logic [31:0] dword_two;
        logic [31:0] definition;
        logic [32:0] verified;
        logic done;
        sbc_disc_t disc;
        logic [2:0] oob_sync;
        logic oob_level;
        logic oob_out;
        logic disc_out;
        logic done_out;
        logic [31:0] rdata;
        logic rvalid;
        logic tx_sel;
    } sbc_state_t;

endpackage : sbc_pkg

// file: sbc_pair_buf.sv
// two-entry buffer between the pattern generator and the transmit path.
// assumes the drain side may hold ready low for any number of cycles.
`timescale 1ns/1ns
`default_nettype none
module sbc_pair_buf (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_clear,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire sbc_pkg::sbc_tx_word_t i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output sbc_pkg::sbc_tx_word_t o_out_data
);
    import sbc_pkg::*;

    sbc_buf_state_t st_reg;
    sbc_buf_state_t st_next;
    logic pop;
    logic push;

    // head always sits in e0, so the output comes straight from a flop
    assign pop = st_reg.v0 & i_out_ready;
    assign push = i_in_valid & ~st_reg.v1;
    assign o_in_ready = ~st_reg.v1;
    assign o_out_valid = st_reg.v0;
    assign o_out_data = st_reg.e0;

    // shift on pop, then fill the first free entry
    always_comb begin
        st_next = st_reg;
        if (pop) begin
            st_next.e0 = st_reg.e1;
            st_next.v0 = st_reg.v1;
            st_next.v1 = 1'b0;
        end
        if (push) begin
            if (!st_next.v0) begin
                st_next.e0 = i_in_data;
                st_next.v0 = 1'b1;
            end else begin
                st_next.e1 = i_in_data;
                st_next.v1 = 1'b1;
            end
        end
        if (i_clear) begin
            st_next.v0 = 1'b0;
            st_next.v1 = 1'b0;
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

endmodule : sbc_pair_buf
`default_nettype wire

// file: sbc_far_end.sv
// far-end sink of the transmit path: takes words, logs them, can stall.
// assumes the bench reads the log through the instance path.
`timescale 1ns/1ns
`default_nettype none
module sbc_far_end (
    input wire logic i_clk,
    input wire logic i_slow,
    input wire logic i_valid,
    input wire sbc_pkg::sbc_tx_word_t i_word,
    output logic o_ready
);
    import sbc_pkg::*;
    // ----------------------------------------
    // sink
    // ----------------------------------------
    logic [1:0] phase_reg = 2'h0;
    sbc_tx_word_t got[$];
    initial o_ready = 1'b0;
    // one ready in four when slow, so the buffer must ride out stalls
    always @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            got.push_back(i_word);
        end
        phase_reg <= phase_reg + 2'h1;
        o_ready <= !i_slow || (phase_reg == 2'h3);
    end
endmodule : sbc_far_end
`default_nettype wire

// file: sbc_selftest_cfg_sva.sv
// checker of the self-test configuration block, bound to its top module.
// assumes one clock domain; reset is asynchronous and active low.
`timescale 1ns/1ns
`default_nettype none
module sbc_cfg_chk (
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    input wire logic I_PM_D3_TO_D0,
    input wire logic I_CFG_WR,
    input wire logic I_CFG_RD,
    input wire logic O_CFG_RVALID,
    input wire logic I_BIST_ACTIVATE,
    input wire logic I_SW_COMRESET,
    input wire logic I_OOB_SIGNAL,
    input wire logic O_OOB_SIGNAL,
    input wire logic O_DISCONNECTED,
    input wire logic I_PATTERN_OK,
    input wire logic O_SELFTEST_DONE
);
    import sbc_pkg::*;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);
    property p_rd_answer; I_CE && I_CFG_RD |=> O_CFG_RVALID; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read unanswered");
    property p_oob_mask; O_DISCONNECTED |-> !O_OOB_SIGNAL; endproperty
    a_oob_mask: assert property (p_oob_mask) else $error("oob seen while cut");
    property p_oob_pass; (I_CE && I_OOB_SIGNAL && !O_DISCONNECTED) [*6] |-> O_OOB_SIGNAL; endproperty
    a_oob_pass: assert property (p_oob_pass) else $error("oob not passed");
    property p_disc_hold; O_DISCONNECTED && !I_SW_COMRESET |=> O_DISCONNECTED; endproperty
    a_disc_hold: assert property (p_disc_hold) else $error("left cut state");
    property p_disc_exit; I_CE && I_SW_COMRESET && !I_BIST_ACTIVATE |=> !O_DISCONNECTED; endproperty
    a_disc_exit: assert property (p_disc_exit) else $error("comreset ignored");
    property p_disc_rise; $rose(O_DISCONNECTED) |-> $past(I_BIST_ACTIVATE); endproperty
    a_disc_rise: assert property (p_disc_rise) else $error("cut without activate");
    property p_done_rise; $rose(O_SELFTEST_DONE) |-> $past(I_PATTERN_OK) || $past(I_PATTERN_OK, 2); endproperty
    a_done_rise: assert property (p_done_rise) else $error("done without pattern");
    property p_done_fall; $fell(O_SELFTEST_DONE) |-> $past(I_CFG_WR, 2) || $past(I_CFG_WR, 3)
        || $past(I_PM_D3_TO_D0) || $past(I_PM_D3_TO_D0, 2); endproperty
    a_done_fall: assert property (p_done_fall) else $error("done dropped alone");
endmodule : sbc_cfg_chk
bind sbc_selftest_cfg sbc_cfg_chk u_chk (.I_MCLK, .I_RST_N, .I_CE, .I_PM_D3_TO_D0, .I_CFG_WR,
    .I_CFG_RD, .O_CFG_RVALID, .I_BIST_ACTIVATE, .I_SW_COMRESET, .I_OOB_SIGNAL, .O_OOB_SIGNAL,
    .O_DISCONNECTED, .I_PATTERN_OK, .O_SELFTEST_DONE);
`default_nettype wire

// file: tb_top.sv
// self-checking bench of the self-test configuration block.
// assumes the far-end sink model and the bound checker compile beside it.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import sbc_pkg::*;
    // ----------------------------------------
    // stimulus and hookup
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0, rd = 1'b0, act = 1'b0, cres = 1'b0, pm = 1'b0, pok = 1'b0;
    logic oob = 1'b0, slow = 1'b1, ce = 1'b1;
    logic [3:0] be = 4'hF;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic rvalid, oob_o, disc, done, txv, txr;
    sbc_tx_word_t txw;
    int error_cnt = 0;
    int tests_run = 0;
    always #25 clk = ~clk;
    sbc_selftest_cfg uut (.I_MCLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_PM_D3_TO_D0(pm),
        .I_CFG_WR(wr), .I_CFG_RD(rd), .I_CFG_ADDR(addr), .I_CFG_BE(be), .I_CFG_WDATA(wdata),
        .O_CFG_RDATA(rdata), .O_CFG_RVALID(rvalid), .I_BIST_ACTIVATE(act),
        .I_SW_COMRESET(cres), .I_OOB_SIGNAL(oob), .O_OOB_SIGNAL(oob_o), .O_DISCONNECTED(disc),
        .I_PATTERN_OK(pok), .O_SELFTEST_DONE(done), .O_TX_VALID(txv), .I_TX_READY(txr),
        .O_TX_WORD(txw));
    sbc_far_end far (.i_clk(clk), .i_slow(slow), .i_valid(txv), .i_word(txw), .o_ready(txr));
    task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset
    // one-cycle write strobe, then one idle cycle
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr32
    // read answers one cycle after the strobe is taken
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rvalid, 1'b1);
        chk(rdata, exp);
    endtask : rdc
    // event strobes {activate, comreset, pm, pattern ok} held n cycles
    task automatic pul(input logic [3:0] m, input int n);
        @(posedge clk);
        {act, cres, pm, pok} <= m;
        repeat (n) @(posedge clk);
        {act, cres, pm, pok} <= 4'h0;
        #1;
    endtask : pul
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_store;
        rdc(8'hDC, 32'h0000_2000);
        rdc(8'hE4, 32'h0);
        rdc(8'hEC, 32'h0);
        wr32(8'hD8, 32'h0000_F23C);
        rdc(8'hD8, 32'h0000_F03C);
        wr32(8'hDC, 32'h0000_0400);
        be <= 4'h1;
        rdc(8'hDC, 32'h0000_0400);
        // only byte lane 0 enabled: upper bytes keep 0000_04
        wr32(8'hDC, 32'hFFFF_FFFF);
        be <= 4'hF;
        rdc(8'hDC, 32'h0000_04FF);
        wr32(8'hE8, 32'h5A5A_F0F0);
        rdc(8'hE8, 32'h5A5A_F0F0);
        wr32(8'hEC, 32'h0000_FFFF);
        rdc(8'hEC, 32'h0000_FFFF);
        wr32(8'hF0, 32'hFFFF_FFFF);
        rdc(8'hF0, 32'h0);
        pul(4'h2, 1);
        rdc(8'hD8, 32'h0000_F000);
        rdc(8'hDC, 32'h0000_2000);
        rdc(8'hE8, 32'h0);
        rdc(8'hEC, 32'h0);
        do_reset;
        rdc(8'hD8, 32'h0);
    endtask : t_store
    task automatic t_count;
        logic [31:0] en;
        wr32(8'hDC, 32'h3);
        for (int k = 0; k < 2; k++) begin
            en = k ? 32'h0400 : 32'h0001;
            wr32(8'hD8, en);
            pul(4'h1, 2);
            repeat (3) @(posedge clk);
            chk(done, 1'b0);
            // clock enable low: the third pattern must be lost
            ce <= 1'b0;
            pul(4'h1, 1);
            chk(done, 1'b0);
            @(posedge clk);
            ce <= 1'b1;
            pul(4'h1, 1);
            repeat (2) @(posedge clk);
            chk(done, 1'b1);
            rdc(8'hD8, en | 32'h0200);
            wr32(8'hD8, en | 32'h0040);
            repeat (2) @(posedge clk);
            chk(done, 1'b0);
            wr32(8'hD8, 32'h0);
        end
        wr32(8'hDC, 32'h0);
        wr32(8'hD8, 32'h0001);
        pul(4'h1, 20);
        repeat (3) @(posedge clk);
        chk(done, 1'b0);
        wr32(8'hD8, 32'h0040);
        wr32(8'hD8, 32'h0);
    endtask : t_count
    task automatic t_disc;
        pul(4'h8, 1);
        chk(disc, 1'b0);
        wr32(8'hD8, 32'h0800);
        oob <= 1'b1;
        repeat (8) @(posedge clk);
        chk(oob_o, 1'b1);
        pul(4'h8, 1);
        chk({disc, oob_o}, 2'b10);
        pul(4'h2, 1);
        // power-state return clears the enable but not the cut state
        rdc(8'hD8, 32'h0);
        wr32(8'hD8, 32'h0800);
        repeat (5) @(posedge clk);
        chk(disc, 1'b1);
        pul(4'h4, 1);
        chk(disc, 1'b0);
        rdc(8'hD8, 32'h0000_0800);
        repeat (6) @(posedge clk);
        chk(oob_o, 1'b1);
        oob <= 1'b0;
        wr32(8'hD8, 32'h0);
    endtask : t_disc
    task automatic t_tmode;
        int base;
        logic [2:0] fl;
        wr32(8'hE4, 32'h1234_5678);
        wr32(8'hE8, 32'h9ABC_DEF0);
        // two passes so the align and scramble bypass flags are each seen set and clear; primitive is set in both
        for (int p = 0; p < 2; p++) begin
            base = far.got.size();
            fl = p ? 3'b101 : 3'b110;
            wr32(8'hEC, p ? 32'h6 : 32'h5);
            wr32(8'hD8, 32'h001D);
            for (int i = 0; i < 300 && far.got.size() < base + 6; i++) @(posedge clk);
            if (far.got.size() < base + 6) begin
                error_cnt++;
                $display("BAD %0t transmit words missing", $time);
                results;
            end
            for (int i = 0; i < 6; i++) begin
                chk(far.got[base + i], {i % 2 ? 32'h9ABC_DEF0 : 32'h1234_5678, fl});
            end
            wr32(8'hD8, 32'h0);
            repeat (3) @(posedge clk);
            chk(txv, 1'b0);
        end
    endtask : t_tmode
    initial begin
        do_reset;
        t_store;
        t_count;
        t_disc;
        t_tmode;
        results;
    end
endmodule : tb_top
`default_nettype wire
